// ### logic/gptb_pkg.sv
// Constants and carrier types shared by the general-purpose timer block
package gptb_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_AMODE = 8'h04;
   localparam logic [7:0] OFS_BMODE = 8'h08;
   localparam logic [7:0] OFS_CTL = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_AILR = 8'h14;
   localparam logic [7:0] OFS_BILR = 8'h18;
   localparam logic [7:0] OFS_AMATCH = 8'h1c;
   localparam logic [7:0] OFS_BMATCH = 8'h20;
   localparam logic [7:0] OFS_APR = 8'h24;
   localparam logic [7:0] OFS_BPR = 8'h28;
   localparam logic [7:0] OFS_APMR = 8'h2c;
   localparam logic [7:0] OFS_BPMR = 8'h30;
   localparam logic [7:0] OFS_ACNT = 8'h34;
   localparam logic [7:0] OFS_BCNT = 8'h38;

   // Configuration values
   localparam logic [2:0] CFG_32_TIMER = 3'h0;
   localparam logic [2:0] CFG_32_RTC = 3'h1;
   localparam logic [2:0] CFG_16_SPLIT = 3'h4;

   // Per-half mode codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_ONESHOT = 3'h1;
   localparam logic [2:0] MODE_PERIODIC = 3'h2;
   localparam logic [2:0] MODE_EDGE_COUNT = 3'h3;
   localparam logic [2:0] MODE_EDGE_TIME = 3'h4;
   localparam logic [2:0] MODE_PWM = 3'h5;

   // Edge select codes
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;

   // Values after reset, and the count loaded when the real-time clock is selected
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [15:0] CNT_RST = 16'hffff;
   localparam logic [15:0] ILR_RST = 16'hffff;
   localparam logic [15:0] MATCH_RST = 16'hffff;
   localparam logic [7:0] PR_RST = 8'h00;
   localparam logic [7:0] PMR_RST = 8'h00;
   localparam logic [15:0] RTC_LOAD = 16'h0001;

   // Rising pin edges per second in real-time clock operation (32768)
   localparam logic [14:0] RTC_DIV_LAST = 15'h7fff;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } gptb_bus_req_t;

   typedef struct packed {
      logic [1:0] pwm_inv;
      logic [1:0] trig_en;
      logic [1:0] stall;
      logic [1:0] en;
   } gptb_ctl_t;

   typedef struct packed {
      logic [1:0] edge_sel;
      logic [2:0] kind;
   } gptb_mode_t;
endpackage

// ### logic/gptb_timer.sv
// General-purpose timer block: two 16-bit counters, joinable to 32 bits
`timescale 1ns/100ps

module gptb_timer
   import gptb_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // Register port
   input wire gptb_bus_req_t i_bus,
   output logic [31:0] o_rdata,
   // Debug halt from the processor
   input wire logic i_dbg_halt,
   // Capture/compare/PWM pins, one per half
   input wire logic [1:0] i_ccp,
   output logic [1:0] o_ccp,
   output logic [1:0] o_ccp_oe_n,
   // Conversion trigger chain
   input wire logic i_adc_trig_chain,
   output logic o_adc_trig
);

   logic [2:0] cfg;
   gptb_mode_t mode [2];
   gptb_ctl_t ctl;
   logic [4:0] status;
   logic [15:0] ilr [2];
   logic [15:0] match [2];
   logic [7:0] pr [2];
   logic [7:0] pmr [2];
   logic [15:0] cnt [2];
   logic [7:0] psc [2];
   logic [15:0] cap [2];
   logic [14:0] rdiv;
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] pin_lvl;
   logic [1:0] pin_lvl_d;
   logic trig_q;
   logic [15:0] next_cnt [2];
   logic [7:0] next_psc [2];
   logic [15:0] next_cap [2];
   logic [14:0] next_rdiv;
   logic [1:0] ev_to;
   logic [1:0] ev_cap;
   logic [1:0] done;
   logic [1:0] trig;
   logic rtc_hit;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] edge_hit;
   logic [1:0] run;
   logic split;
   logic is_rtc;
   logic [31:0] c32;
   logic wr_cfg;
   logic wr_ailr;
   logic wr_bilr;
   assign split = (cfg == CFG_16_SPLIT);
   assign is_rtc = (cfg == CFG_32_RTC);
   assign c32 = {cnt[1], cnt[0]};
   assign wr_cfg = i_bus.wr && (i_bus.addr == OFS_CFG);
   assign wr_ailr = i_bus.wr && (i_bus.addr == OFS_AILR);
   assign wr_bilr = i_bus.wr && (i_bus.addr == OFS_BILR);
   // Pin synchroniser; a level counts once stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
         sync3 <= 2'h0;
         pin_lvl <= 2'h0;
         pin_lvl_d <= 2'h0;
      end else begin
         sync1 <= i_ccp;
         sync2 <= sync1;
         sync3 <= sync2;
         pin_lvl <= (sync2 & sync3) | (pin_lvl & (sync2 ^ sync3));
         pin_lvl_d <= pin_lvl;
      end
   end
   assign rise = pin_lvl & ~pin_lvl_d;
   assign fall = ~pin_lvl & pin_lvl_d;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (mode[i].edge_sel)
            EDGE_RISE: edge_hit[i] = rise[i];
            EDGE_FALL: edge_hit[i] = fall[i];
            default: edge_hit[i] = rise[i] | fall[i];
         endcase
         run[i] = ctl.en[i] && !(ctl.stall[i] && i_dbg_halt);
      end
   end

   // Counting behaviour for every configuration
   always_comb begin
      next_cnt = cnt;
      next_psc = psc;
      next_cap = cap;
      next_rdiv = rdiv;
      ev_to = 2'h0;
      ev_cap = 2'h0;
      done = 2'h0;
      trig = 2'h0;
      rtc_hit = 1'b0;
      if (split) begin
         for (int i = 0; i < 2; i++) begin
            unique case (mode[i].kind)
               MODE_ONESHOT, MODE_PERIODIC: begin
                  if (run[i]) begin
                     if (cnt[i] == 16'h0000) begin
                        next_cnt[i] = ilr[i];
                        next_psc[i] = pr[i];
                        ev_to[i] = 1'b1;
                        trig[i] = ctl.trig_en[i];
                        done[i] = (mode[i].kind == MODE_ONESHOT);
                     end else if (psc[i] == 8'h00) begin
                        next_cnt[i] = cnt[i] - 16'h0001;
                        next_psc[i] = pr[i];
                     end else begin
                        next_psc[i] = psc[i] - 8'h01;
                     end
                  end
               end
               MODE_EDGE_COUNT: begin
                  // Reloads and stops at the match so software sees a settled count
                  if (run[i] && edge_hit[i]) begin
                     if (cnt[i] == match[i]) begin
                        next_cnt[i] = ilr[i];
                        ev_cap[i] = 1'b1;
                        done[i] = 1'b1;
                     end else begin
                        next_cnt[i] = cnt[i] - 16'h0001;
                     end
                  end
               end
               MODE_EDGE_TIME: begin
                  if (run[i]) begin
                     next_cnt[i] = (cnt[i] == 16'h0000) ? ilr[i] : cnt[i] - 16'h0001;
                     if (edge_hit[i]) begin
                        next_cap[i] = cnt[i];
                        ev_cap[i] = 1'b1;
                     end
                  end
               end
               MODE_PWM: begin
                  if (run[i]) next_cnt[i] = (cnt[i] == 16'h0000) ? ilr[i] : cnt[i] - 16'h0001;
               end
               default: ;
            endcase
         end
      end else if (is_rtc) begin
         // No stall here: wall time must keep running under debug
         if (ctl.en[0] && rise[0]) begin
            next_rdiv = rdiv + 15'h0001;
            if (rdiv == RTC_DIV_LAST) begin
               next_rdiv = 15'h0000;
               if (c32 == {match[1], match[0]}) begin
                  {next_cnt[1], next_cnt[0]} = 32'h0000_0000;
                  rtc_hit = 1'b1;
               end else begin
                  {next_cnt[1], next_cnt[0]} = c32 + 32'h0000_0001;
               end
            end
         end
      end else begin
         // Halves act as one down-counter; the second mode is ignored
         if (run[0] && (mode[0].kind == MODE_ONESHOT || mode[0].kind == MODE_PERIODIC)) begin
            if (c32 == 32'h0000_0000) begin
               {next_cnt[1], next_cnt[0]} = {ilr[1], ilr[0]};
               ev_to[0] = 1'b1;
               trig[0] = ctl.trig_en[0];
               done[0] = (mode[0].kind == MODE_ONESHOT);
            end else begin
               {next_cnt[1], next_cnt[0]} = c32 - 32'h0000_0001;
            end
         end
      end
      // A load written while running is taken on the next edge
      if (wr_cfg && i_bus.wdata[2:0] == CFG_32_RTC) begin
         next_cnt[0] = RTC_LOAD;
         next_cnt[1] = 16'h0000;
         next_rdiv = 15'h0000;
      end
      if (wr_ailr) begin
         next_cnt[0] = i_bus.wdata[15:0];
         next_psc[0] = pr[0];
         if (!split) next_cnt[1] = i_bus.wdata[31:16];
      end
      if (wr_bilr) begin
         next_cnt[1] = i_bus.wdata[15:0];
         next_psc[1] = pr[1];
      end
   end

   // Counter state
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < 2; i++) begin
            cnt[i] <= CNT_RST;
            psc[i] <= PR_RST;
            cap[i] <= 16'h0000;
         end
         rdiv <= 15'h0000;
      end else begin
         cnt <= next_cnt;
         psc <= next_psc;
         cap <= next_cap;
         rdiv <= next_rdiv;
      end
   end

   // Configuration, mode and control registers
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg <= CFG_RST;
         mode[0] <= '0;
         mode[1] <= '0;
         ctl <= '0;
      end else begin
         if (wr_cfg) cfg <= i_bus.wdata[2:0];
         if (i_bus.wr && i_bus.addr == OFS_AMODE) mode[0] <= gptb_mode_t'(i_bus.wdata[4:0]);
         if (i_bus.wr && i_bus.addr == OFS_BMODE) mode[1] <= gptb_mode_t'(i_bus.wdata[4:0]);
         // A software write beats the one-shot self-clear of enable
         if (i_bus.wr && i_bus.addr == OFS_CTL) begin
            ctl <= gptb_ctl_t'(i_bus.wdata[7:0]);
         end else begin
            ctl.en <= ctl.en & ~done;
         end
      end
   end

   // Load, match and prescale registers
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < 2; i++) begin
            ilr[i] <= ILR_RST;
            match[i] <= MATCH_RST;
            pr[i] <= PR_RST;
            pmr[i] <= PMR_RST;
         end
      end else if (i_bus.wr) begin
         unique case (i_bus.addr)
            OFS_AILR: begin
               ilr[0] <= i_bus.wdata[15:0];
               if (!split) ilr[1] <= i_bus.wdata[31:16];
            end
            OFS_BILR: ilr[1] <= i_bus.wdata[15:0];
            OFS_AMATCH: match[0] <= i_bus.wdata[15:0];
            OFS_BMATCH: match[1] <= i_bus.wdata[15:0];
            OFS_APR: pr[0] <= i_bus.wdata[7:0];
            OFS_BPR: pr[1] <= i_bus.wdata[7:0];
            OFS_APMR: pmr[0] <= i_bus.wdata[7:0];
            OFS_BPMR: pmr[1] <= i_bus.wdata[7:0];
            default: ;
         endcase
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         status <= 5'h00;
      end else begin
         status <= (status & ~((i_bus.wr && i_bus.addr == OFS_STATUS) ?
                              i_bus.wdata[4:0] : 5'h00))
                   | {rtc_hit, ev_cap[1], ev_to[1], ev_cap[0], ev_to[0]};
      end
   end

   // Pins and trigger
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ccp <= 2'h0;
         o_ccp_oe_n <= 2'h3;
         trig_q <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            o_ccp[i] <= (cnt[i] > match[i]) ^ ctl.pwm_inv[i];
            // Pad mux outside must also pick the timer function
            o_ccp_oe_n[i] <= !(split && mode[i].kind == MODE_PWM);
         end
         trig_q <= |trig;
      end
   end
   assign o_adc_trig = trig_q | i_adc_trig_chain;
   // Read data, one cycle after the strobe
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_bus.rd) begin
         unique case (i_bus.addr)
            OFS_CFG: o_rdata <= {29'h0, cfg};
            OFS_AMODE: o_rdata <= {27'h0, mode[0]};
            OFS_BMODE: o_rdata <= {27'h0, mode[1]};
            OFS_CTL: o_rdata <= {24'h0, ctl};
            OFS_STATUS: o_rdata <= {27'h0, status};
            OFS_AILR: o_rdata <= split ? {16'h0, ilr[0]} : {ilr[1], ilr[0]};
            OFS_BILR: o_rdata <= {16'h0, ilr[1]};
            OFS_AMATCH: o_rdata <= {16'h0, match[0]};
            OFS_BMATCH: o_rdata <= {16'h0, match[1]};
            OFS_APR: o_rdata <= {24'h0, pr[0]};
            OFS_BPR: o_rdata <= {24'h0, pr[1]};
            OFS_APMR: o_rdata <= {24'h0, pmr[0]};
            OFS_BPMR: o_rdata <= {24'h0, pmr[1]};
            OFS_ACNT: o_rdata <= !split ? c32 : {16'h0, (mode[0].kind == MODE_EDGE_TIME) ?
                                                 cap[0] : cnt[0]};
            OFS_BCNT: o_rdata <= {16'h0, (split && mode[1].kind == MODE_EDGE_TIME) ?
                                         cap[1] : cnt[1]};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule

// ### verif/gptb_timer_sva.sv
// Concurrent checks on the timer block's ports
`timescale 1ns/100ps
module gptb_timer_sva
   import gptb_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   // Watched ports
   input wire gptb_bus_req_t i_bus,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_ccp,
   input wire logic [1:0] o_ccp_oe_n,
   input wire logic i_adc_trig_chain,
   input wire logic o_adc_trig
);
   logic [2:0] cfg;
   logic [2:0] mode_a;
   logic [1:0] trig_en;
   wire mapped = i_bus.addr <= OFS_BCNT && i_bus.addr[1:0] == 2'h0;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   // Shadow of the writes that gate pin drive and triggers
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg <= CFG_RST;
         mode_a <= MODE_OFF;
         trig_en <= 2'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == OFS_CFG) cfg <= i_bus.wdata[2:0];
         if (i_bus.addr == OFS_AMODE) mode_a <= i_bus.wdata[2:0];
         if (i_bus.addr == OFS_CTL) trig_en <= i_bus.wdata[5:4];
      end
   end

   sequence wr_s(logic [7:0] a);
      i_bus.wr && i_bus.addr == a;
   endsequence
   sequence rd_s(logic [7:0] a);
      i_bus.rd && i_bus.addr == a;
   endsequence

   rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (i_bus.rd && !mapped |=> o_rdata == 32'h0)
      else $error("unmapped read returned data");
   trig_chain_a: assert property (i_adc_trig_chain |-> o_adc_trig)
      else $error("chained trigger not passed on");
   trig_enable_a: assert property (o_adc_trig && !i_adc_trig_chain |->
      trig_en != 2'h0 || $past(trig_en) != 2'h0 || $past(trig_en, 2) != 2'h0)
      else $error("trigger without trigger enable");
   pins_released_a: assert property (cfg != CFG_16_SPLIT && $past(cfg) != CFG_16_SPLIT
      |-> o_ccp_oe_n == 2'b11)
      else $error("pin driven in joined configuration");
   pwm_drive_a: assert property (!o_ccp_oe_n[0] |->
      mode_a == MODE_PWM || $past(mode_a) == MODE_PWM)
      else $error("first pin driven outside pwm mode");
   reset_pins_a: assert property ($rose(i_arst_n) |-> o_ccp_oe_n == 2'b11 && o_ccp == 2'b00)
      else $error("pins active out of reset");
   cfg_readback_a: assert property (wr_s(OFS_CFG) ##1 !i_bus.wr ##1 rd_s(OFS_CFG)
      |=> o_rdata == {29'h0, $past(i_bus.wdata[2:0], 3)})
      else $error("configuration readback wrong");
   ctl_readback_a: assert property (wr_s(OFS_CTL) ##1 !i_bus.wr ##1 rd_s(OFS_CTL)
      |=> o_rdata[7:2] == $past(i_bus.wdata[7:2], 3))
      else $error("control readback wrong");
endmodule

// ### verif/gptb_pin_model.sv
// Shared pins: port mux, pull-up and the outside signal source
`timescale 1ns/100ps
module gptb_pin_model (
   // Mux and outside source
   input wire logic [1:0] i_alt_sel,
   input wire logic [1:0] i_ext_lvl,
   // Timer side
   input wire logic [1:0] i_ccp_out,
   input wire logic [1:0] i_ccp_oe_n,
   // Pin level
   output logic [1:0] o_pin
);
   // Unselected pins stay with the port and idle high on the pull-up
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         if (!i_alt_sel[k]) o_pin[k] = 1'b1;
         else if (!i_ccp_oe_n[k]) o_pin[k] = i_ccp_out[k];
         else o_pin[k] = i_ext_lvl[k];
      end
   end
endmodule

// ### verif/gptb_timer_tb_top.sv
// Register-level bench for the general-purpose timer block
`timescale 1ns/100ps
module gptb_timer_tb_top
   import gptb_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   gptb_bus_req_t bus = '0;
   logic halt = 1'b0;
   logic chain = 1'b0;
   logic [1:0] alt_sel = 2'h0;
   logic [1:0] ext_lvl = 2'h0;
   logic [31:0] rdata;
   logic [1:0] ccp_out;
   logic [1:0] oe_n;
   logic [1:0] pin;
   logic trig;
   logic [31:0] got;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int n_trig = 0;
   int trig_cyc = 0;
   int t0;
   int highs;

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (trig && !chain) begin
         n_trig++;
         trig_cyc = cyc;
      end
   end

   gptb_timer DUT (.i_sys_clk(clk), .i_arst_n(arst_n), .i_bus(bus), .o_rdata(rdata),
      .i_dbg_halt(halt), .i_ccp(pin), .o_ccp(ccp_out), .o_ccp_oe_n(oe_n),
      .i_adc_trig_chain(chain), .o_adc_trig(trig));
   gptb_pin_model u_pins (.i_alt_sel(alt_sel), .i_ext_lvl(ext_lvl), .i_ccp_out(ccp_out),
      .i_ccp_oe_n(oe_n), .o_pin(pin));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
      checked++;
      if (act !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, act);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a, got);
      chk($sformatf("reg %h", a), exp, got);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #500000;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      rdc(OFS_CFG, 32'h0);
      rdc(OFS_CTL, 32'h0);
      rdc(OFS_AILR, 32'hffffffff);
      rdc(OFS_ACNT, 32'hffffffff);
      rdc(OFS_APR, 32'h0);
      rdc(OFS_BPR, 32'h0);
      rdc(8'h3c, 32'h0);
      wr(OFS_AILR, 32'h00020003);
      rdc(OFS_AILR, 32'h00020003);
      rdc(OFS_ACNT, 32'h00020003);
      // Split one-shot, prescale 2 on a load of 3: about nine clocks to zero
      wr(OFS_CFG, {29'h0, CFG_16_SPLIT});
      rdc(OFS_CFG, 32'h4);
      wr(OFS_AMODE, {29'h0, MODE_ONESHOT});
      wr(OFS_APR, 32'h2);
      wr(OFS_AILR, 32'h3);
      wr(OFS_CTL, 32'h11);
      t0 = cyc;
      got = '0;
      for (int i = 0; i < 20 && got[0] !== 1'b1; i++) rd(OFS_STATUS, got);
      chk("timeout flag", 32'h1, got & 32'h1);
      chk("trigger pulses", 32'h1, n_trig);
      chk("prescaled delay", 32'h1, trig_cyc - t0 >= 9 && trig_cyc - t0 <= 14);
      rdc(OFS_CTL, 32'h10);
      // Three rising edges on the second pin reach the match value
      alt_sel <= 2'b11;
      wr(OFS_BMODE, {27'h0, EDGE_RISE, MODE_EDGE_COUNT});
      wr(OFS_BILR, 32'h3);
      wr(OFS_BMATCH, 32'h1);
      wr(OFS_CTL, 32'h02);
      repeat (3) begin
         repeat (4) @(posedge clk);
         ext_lvl[1] <= 1'b1;
         repeat (4) @(posedge clk);
         ext_lvl[1] <= 1'b0;
      end
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, got);
      chk("edge match flag", 32'h8, got & 32'h8);
      // PWM: nine counts a period, high while the count is above 3
      wr(OFS_AMODE, {29'h0, MODE_PWM});
      wr(OFS_AMATCH, 32'h3);
      wr(OFS_AILR, 32'h8);
      // Invert bit of the first half is bit 6
      for (int inv = 0; inv < 2; inv++) begin
         wr(OFS_CTL, inv ? 32'h41 : 32'h01);
         repeat (4) @(posedge clk);
         highs = 0;
         repeat (18) begin
            @(posedge clk);
            highs += pin[0];
         end
         chk("pwm high cycles", inv ? 32'h8 : 32'ha, highs);
         chk("pwm drive", 32'h0, {31'h0, oe_n[0]});
      end
      // Halt freezes the second half while its stall bit is set
      wr(OFS_BMODE, {29'h0, MODE_PERIODIC});
      wr(OFS_CTL, 32'h0a);
      rdc(OFS_CTL, 32'h0a);
      halt <= 1'b1;
      wr(OFS_BILR, 32'h1234);
      repeat (5) @(posedge clk);
      rdc(OFS_BCNT, 32'h1234);
      halt <= 1'b0;
      repeat (5) @(posedge clk);
      rd(OFS_BCNT, got);
      chk("running count", 32'h1, got < 32'h1234);
      // Falling-edge time capture; the rising edge before it must not count
      wr(OFS_STATUS, 32'h1f);
      rdc(OFS_STATUS, 32'h0);
      wr(OFS_BMODE, {27'h0, EDGE_FALL, MODE_EDGE_TIME});
      ext_lvl[1] <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(OFS_STATUS, 32'h0);
      ext_lvl[1] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(OFS_STATUS, got);
      chk("capture flag", 32'h8, got);
      rd(OFS_BCNT, got);
      chk("captured time", 32'h1, got < 32'h1234);
      // Joined halves borrow from the upper half on the first count
      wr(OFS_CFG, {29'h0, CFG_32_TIMER});
      wr(OFS_AMODE, {29'h0, MODE_ONESHOT});
      wr(OFS_AILR, 32'h00010000);
      wr(OFS_CTL, 32'h01);
      rdc(OFS_ACNT, 32'h0000ffff);
      // Real-time clock loads one; a few pin edges stay inside the divider
      wr(OFS_CFG, {29'h0, CFG_32_RTC});
      rdc(OFS_ACNT, 32'h1);
      repeat (3) begin
         ext_lvl[0] <= 1'b1;
         repeat (4) @(posedge clk);
         ext_lvl[0] <= 1'b0;
         repeat (4) @(posedge clk);
      end
      rdc(OFS_ACNT, 32'h1);
      chain <= 1'b1;
      @(posedge clk);
      #1;
      chk("trigger chain", 32'h1, {31'h0, trig});
      print_verdict();
   end
endmodule

bind gptb_timer gptb_timer_sva u_sva (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
   .i_bus(i_bus), .o_rdata(o_rdata), .o_ccp(o_ccp), .o_ccp_oe_n(o_ccp_oe_n),
   .i_adc_trig_chain(i_adc_trig_chain), .o_adc_trig(o_adc_trig));
